// ==== hw/ext_bus_pkg.sv ====
package ext_bus_pkg;

  // one strobe slot lasts this many oscillator periods (one clk_i edge each)
  localparam int unsigned SLOT_CYCLES = 6;
  localparam logic [2:0] PHASE_LAST = 3'(SLOT_CYCLES - 1);
  localparam logic [2:0] PHASE_FIRST = 3'h0;
  // address latch strobe is high on phases 0..ALE_END_PHASE
  localparam logic [2:0] ALE_END_PHASE = 3'h1;
  // low port keeps the address on the lines through ADDR_END_PHASE
  localparam logic [2:0] ADDR_END_PHASE = 3'h2;
  // program store strobe is low from PROGRAM_STORE_STROBE_START_PHASE to the slot end
  localparam logic [2:0] PROGRAM_STORE_STROBE_START_PHASE = 3'h3;
  // data memory read/write strobe window inside the data slot
  localparam logic [2:0] XSTROBE_START_PHASE = 3'h1;
  localparam logic [2:0] XSTROBE_END_PHASE = 3'h4;

  localparam logic [15:0] INTERNAL_ROM_LIMIT = 16'h8000;
  localparam logic [7:0] PORT_LATCH_RESET = 8'hFF;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] DRIVE_ALL = 8'hFF;

  typedef enum logic [1:0] {
    SLOT_FETCH = 2'b00,
    SLOT_XADDR = 2'b01,
    SLOT_XDATA = 2'b10
  } slot_e;

  function automatic logic fetch_is_external(input logic [15:0] pc, input logic sel);
    return (!sel) || (pc >= INTERNAL_ROM_LIMIT);
  endfunction : fetch_is_external

endpackage : ext_bus_pkg

// ==== hw/external_memory_bus_port.sv ====
`timescale 1ns/1ps

module external_memory_bus_port (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // fetch side
  input wire logic external_access_select_i,
  input wire logic [15:0] pc_i,
  output logic code_valid_o,
  output logic [7:0] code_byte_o,
  // data memory requests
  input wire logic xmem_req_i,
  input wire logic xmem_wide_i,
  input wire logic xmem_write_i,
  input wire logic [15:0] xmem_addr_i,
  input wire logic [7:0] xmem_wdata_i,
  output logic xmem_busy_o,
  output logic xmem_done_o,
  output logic [7:0] xmem_rdata_o,
  // port latch writes
  input wire logic low_latch_wr_i,
  input wire logic high_latch_wr_i,
  input wire logic [7:0] latch_data_i,
  // strobes
  output logic program_store_strobe_n_o,
  output logic address_latch_strobe_o,
  output logic xdata_read_n_o,
  output logic xdata_write_n_o,
  // low address/data port pins
  input wire logic [7:0] low_address_data_port_i,
  output logic [7:0] low_address_data_port_o,
  output logic [7:0] low_address_data_port_oe_o,
  // high address port pins
  output logic [7:0] high_address_port_o,
  output logic [7:0] high_address_port_oe_o,
  output logic [7:0] high_address_port_pullup_o
);

  logic [2:0] phase_ff;
  ext_bus_pkg::slot_e slot_ff;
  logic ext_ff;
  logic [15:0] addr_ff;
  logic req_pend_ff;
  logic req_wide_ff;
  logic req_write_ff;
  logic [15:0] req_addr_ff;
  logic [7:0] req_wdata_ff;
  logic [7:0] low_latch_ff;
  logic [7:0] high_latch_ff;
  logic boundary;
  logic [2:0] nxt_phase;
  ext_bus_pkg::slot_e nxt_slot;
  logic nxt_ext;
  logic [15:0] nxt_addr;
  logic nxt_ale;
  logic nxt_program_store_strobe_n;
  logic nxt_rd_n;
  logic nxt_wr_n;
  logic [7:0] nxt_lo;
  logic [7:0] nxt_lo_oe;
  logic [7:0] nxt_hi;
  logic [7:0] nxt_hi_oe;
  logic [7:0] nxt_hi_pull;
  default clocking dcb @(posedge clk_i);
  endclocking : dcb
  default disable iff (!rst_n_i);

  assign boundary = (phase_ff == ext_bus_pkg::PHASE_LAST);
  // slot sequencing: fetch slots run back to back; a data access takes an
  // address slot and a data slot, inserted at the next slot boundary
  always_comb begin
    nxt_phase = boundary ? ext_bus_pkg::PHASE_FIRST : 3'(phase_ff + 3'h1);
    nxt_slot = slot_ff;
    nxt_ext = ext_ff;
    nxt_addr = addr_ff;
    if (boundary) begin
      unique case (slot_ff)
        ext_bus_pkg::SLOT_XADDR: nxt_slot = ext_bus_pkg::SLOT_XDATA;
        ext_bus_pkg::SLOT_XDATA: nxt_slot = ext_bus_pkg::SLOT_FETCH;
        ext_bus_pkg::SLOT_FETCH: begin
          nxt_slot = req_pend_ff ? ext_bus_pkg::SLOT_XADDR : ext_bus_pkg::SLOT_FETCH;
        end
        default: nxt_slot = ext_bus_pkg::SLOT_FETCH;
      endcase
      nxt_ext = ext_bus_pkg::fetch_is_external(pc_i, external_access_select_i);
      nxt_addr = (nxt_slot == ext_bus_pkg::SLOT_FETCH) ? pc_i : req_addr_ff;
    end
  end
  // pins decode the next state so they change with the state registers
  always_comb begin
    nxt_ale = (nxt_slot != ext_bus_pkg::SLOT_XDATA) &&
              (nxt_phase <= ext_bus_pkg::ALE_END_PHASE);
    nxt_program_store_strobe_n = !((nxt_slot == ext_bus_pkg::SLOT_FETCH) && nxt_ext &&
                   (nxt_phase >= ext_bus_pkg::PROGRAM_STORE_STROBE_START_PHASE));
    nxt_rd_n = 1'b1;
    nxt_wr_n = 1'b1;
    if ((nxt_slot == ext_bus_pkg::SLOT_XDATA) &&
        (nxt_phase >= ext_bus_pkg::XSTROBE_START_PHASE) &&
        (nxt_phase <= ext_bus_pkg::XSTROBE_END_PHASE)) begin
      nxt_rd_n = req_write_ff;
      nxt_wr_n = !req_write_ff;
    end
    // plain port: open drain, only zeros are driven
    nxt_lo = ext_bus_pkg::BYTE_ZERO;
    nxt_lo_oe = ~low_latch_ff;
    unique case (nxt_slot)
      ext_bus_pkg::SLOT_FETCH: begin
        if (nxt_ext) begin
          // address first, then release so memory can return the code byte
          nxt_lo = nxt_addr[7:0];
          nxt_lo_oe = (nxt_phase <= ext_bus_pkg::ADDR_END_PHASE) ?
                      ext_bus_pkg::DRIVE_ALL : ext_bus_pkg::BYTE_ZERO;
        end
      end
      ext_bus_pkg::SLOT_XADDR: begin
        nxt_lo = nxt_addr[7:0];
        nxt_lo_oe = ext_bus_pkg::DRIVE_ALL;
      end
      ext_bus_pkg::SLOT_XDATA: begin
        nxt_lo = req_wdata_ff;
        nxt_lo_oe = req_write_ff ? ext_bus_pkg::DRIVE_ALL : ext_bus_pkg::BYTE_ZERO;
      end
      default: nxt_lo_oe = ext_bus_pkg::BYTE_ZERO;
    endcase
    if (((nxt_slot == ext_bus_pkg::SLOT_FETCH) && nxt_ext) ||
        ((nxt_slot != ext_bus_pkg::SLOT_FETCH) && req_wide_ff)) begin
      nxt_hi = nxt_addr[15:8];
      nxt_hi_oe = ext_bus_pkg::DRIVE_ALL;
      nxt_hi_pull = ext_bus_pkg::BYTE_ZERO;
    end else begin
      // narrow accesses and plain use both show the latch, quasi-bidirectional
      nxt_hi = high_latch_ff;
      nxt_hi_oe = ~high_latch_ff;
      nxt_hi_pull = high_latch_ff;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_ff <= ext_bus_pkg::PHASE_FIRST;
      slot_ff <= ext_bus_pkg::SLOT_FETCH;
      ext_ff <= 1'b0;
      addr_ff <= ext_bus_pkg::ADDR_RESET;
    end else begin
      phase_ff <= nxt_phase;
      slot_ff <= nxt_slot;
      ext_ff <= nxt_ext;
      addr_ff <= nxt_addr;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      address_latch_strobe_o <= 1'b0;
      program_store_strobe_n_o <= 1'b1;
      xdata_read_n_o <= 1'b1;
      xdata_write_n_o <= 1'b1;
      low_address_data_port_o <= ext_bus_pkg::BYTE_ZERO;
      low_address_data_port_oe_o <= ext_bus_pkg::BYTE_ZERO;
      high_address_port_o <= ext_bus_pkg::PORT_LATCH_RESET;
      high_address_port_oe_o <= ext_bus_pkg::BYTE_ZERO;
      high_address_port_pullup_o <= ext_bus_pkg::PORT_LATCH_RESET;
    end else begin
      address_latch_strobe_o <= nxt_ale;
      program_store_strobe_n_o <= nxt_program_store_strobe_n;
      xdata_read_n_o <= nxt_rd_n;
      xdata_write_n_o <= nxt_wr_n;
      low_address_data_port_o <= nxt_lo;
      low_address_data_port_oe_o <= nxt_lo_oe;
      high_address_port_o <= nxt_hi;
      high_address_port_oe_o <= nxt_hi_oe;
      high_address_port_pullup_o <= nxt_hi_pull;
    end
  end

  // one request is held at a time; busy refuses new ones until done
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_pend_ff <= 1'b0;
      req_wide_ff <= 1'b0;
      req_write_ff <= 1'b0;
      req_addr_ff <= ext_bus_pkg::ADDR_RESET;
      req_wdata_ff <= ext_bus_pkg::BYTE_ZERO;
    end else if (xmem_req_i && !req_pend_ff) begin
      req_pend_ff <= 1'b1;
      req_wide_ff <= xmem_wide_i;
      req_write_ff <= xmem_write_i;
      req_addr_ff <= xmem_addr_i;
      req_wdata_ff <= xmem_wdata_i;
    end else if (boundary && (slot_ff == ext_bus_pkg::SLOT_XDATA)) begin
      req_pend_ff <= 1'b0;
    end
  end
  assign xmem_busy_o = req_pend_ff;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_latch_ff <= ext_bus_pkg::PORT_LATCH_RESET;
      high_latch_ff <= ext_bus_pkg::PORT_LATCH_RESET;
    end else begin
      if (low_latch_wr_i) begin
        low_latch_ff <= latch_data_i;
      end
      if (high_latch_wr_i) begin
        high_latch_ff <= latch_data_i;
      end
    end
  end

  // code byte is taken on the last edge of the strobe-low window, before release
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      code_valid_o <= 1'b0;
      code_byte_o <= ext_bus_pkg::BYTE_ZERO;
      xmem_done_o <= 1'b0;
      xmem_rdata_o <= ext_bus_pkg::BYTE_ZERO;
    end else begin
      code_valid_o <= boundary && (slot_ff == ext_bus_pkg::SLOT_FETCH) && ext_ff;
      if (boundary && (slot_ff == ext_bus_pkg::SLOT_FETCH) && ext_ff) begin
        code_byte_o <= low_address_data_port_i;
      end
      xmem_done_o <= boundary && (slot_ff == ext_bus_pkg::SLOT_XDATA);
      if ((slot_ff == ext_bus_pkg::SLOT_XDATA) && !req_write_ff &&
          (phase_ff == ext_bus_pkg::XSTROBE_END_PHASE)) begin
        xmem_rdata_o <= low_address_data_port_i;
      end
    end
  end

  property p_program_store_strobe_window;
    (slot_ff == ext_bus_pkg::SLOT_FETCH && ext_ff &&
     phase_ff == ext_bus_pkg::PROGRAM_STORE_STROBE_START_PHASE) |->
      (!program_store_strobe_n_o) [*3] ##1 program_store_strobe_n_o;
  endproperty
  a_program_store_strobe_window: assert property (p_program_store_strobe_window) else $error("strobe window wrong");
  property p_program_store_strobe_not_data;
    (slot_ff != ext_bus_pkg::SLOT_FETCH) |-> program_store_strobe_n_o;
  endproperty
  a_program_store_strobe_not_data: assert property (p_program_store_strobe_not_data) else $error("strobe in data slot");
  property p_program_store_strobe_internal;
    (slot_ff == ext_bus_pkg::SLOT_FETCH && !ext_ff) |-> program_store_strobe_n_o;
  endproperty
  a_program_store_strobe_internal: assert property (p_program_store_strobe_internal) else $error("strobe on internal");
  property p_ale_pulse;
    ($past(rst_n_i) && phase_ff == ext_bus_pkg::PHASE_FIRST &&
     slot_ff != ext_bus_pkg::SLOT_XDATA) |->
      address_latch_strobe_o [*2] ##1 !address_latch_strobe_o;
  endproperty
  a_ale_pulse: assert property (p_ale_pulse) else $error("latch strobe pulse wrong");
  property p_ale_skip;
    (slot_ff == ext_bus_pkg::SLOT_XDATA) |-> !address_latch_strobe_o;
  endproperty
  a_ale_skip: assert property (p_ale_skip) else $error("latch strobe in data slot");
  property p_sel_internal;
    (boundary && external_access_select_i && pc_i < ext_bus_pkg::INTERNAL_ROM_LIMIT) |=> !ext_ff;
  endproperty
  a_sel_internal: assert property (p_sel_internal) else $error("low pc went external");
  property p_sel_external;
    (boundary && (!external_access_select_i ||
                  pc_i >= ext_bus_pkg::INTERNAL_ROM_LIMIT)) |=> ext_ff;
  endproperty
  a_sel_external: assert property (p_sel_external) else $error("fetch stayed internal");
  property p_high_addr;
    (slot_ff == ext_bus_pkg::SLOT_FETCH && ext_ff) |->
      (high_address_port_o == addr_ff[15:8] && high_address_port_oe_o == 8'hFF);
  endproperty
  a_high_addr: assert property (p_high_addr) else $error("high address missing");
  property p_high_latch;
    (slot_ff != ext_bus_pkg::SLOT_FETCH && !req_wide_ff && $stable(high_latch_ff)) |->
      (high_address_port_o == high_latch_ff && high_address_port_pullup_o == high_latch_ff);
  endproperty
  a_high_latch: assert property (p_high_latch) else $error("latch not shown");
  property p_low_mux;
    (slot_ff == ext_bus_pkg::SLOT_XADDR && req_write_ff &&
     phase_ff == ext_bus_pkg::PHASE_LAST) |->
      (low_address_data_port_o == req_addr_ff[7:0]) ##1
      (low_address_data_port_o == req_wdata_ff && low_address_data_port_oe_o == 8'hFF);
  endproperty
  a_low_mux: assert property (p_low_mux) else $error("address then data order wrong");
  property p_low_open_drain;
    (slot_ff == ext_bus_pkg::SLOT_FETCH && !ext_ff && $stable(low_latch_ff)) |->
      (low_address_data_port_o == 8'h00 && low_address_data_port_oe_o == ~low_latch_ff);
  endproperty
  a_low_open_drain: assert property (p_low_open_drain) else $error("low port not open drain");

endmodule : external_memory_bus_port

// ==== testbench/ext_memory_model.sv ====
`timescale 1ns/1ps

module ext_memory_model (
  // clock
  input wire logic clk_i,
  // strobes from the device
  input wire logic address_latch_strobe_i,
  input wire logic program_store_strobe_n_i,
  input wire logic xdata_read_n_i,
  input wire logic xdata_write_n_i,
  // device pins
  input wire logic [7:0] low_port_i,
  input wire logic [7:0] low_port_oe_i,
  input wire logic [7:0] high_port_i,
  // resolved low port wire level
  output logic [7:0] pin_o
);
  logic [7:0] addr_lo_ff;
  logic [7:0] last_ff;
  logic [7:0] dmem [0:65535];
  logic [7:0] mem_byte;
  logic mem_en;

  always_ff @(negedge address_latch_strobe_i) addr_lo_ff <= pin_o;
  always_ff @(posedge clk_i) last_ff <= pin_o;
  always_ff @(posedge xdata_write_n_i) dmem[{high_port_i, addr_lo_ff}] <= pin_o;

  assign mem_en = !program_store_strobe_n_i || !xdata_read_n_i;
  // code bytes follow a fixed pattern of the address so every fetch is checkable
  assign mem_byte = !program_store_strobe_n_i ? (addr_lo_ff ^ high_port_i ^ 8'h3C)
                    : dmem[{high_port_i, addr_lo_ff}];
  // no pull on these lines: an undriven bit shows the inverse of its last level
  assign pin_o = (low_port_oe_i & low_port_i)
                 | (~low_port_oe_i & (mem_en ? mem_byte : ~last_ff));
endmodule : ext_memory_model

// ==== testbench/test_external_memory_bus_port.sv ====
`timescale 1ns/1ps

module test_external_memory_bus_port;
  logic clk_i = 1'b0, rst_n_i = 1'b0, sel = 1'b1, req = 1'b0, wide = 1'b0, wr = 1'b0;
  logic low_wr = 1'b0, high_wr = 1'b0;
  logic [15:0] pc = 16'h0000, xaddr = 16'h0000;
  logic [7:0] wdata = 8'h00, latch = 8'hFF;
  logic code_valid, busy, done, program_store_strobe_n, ale, rd_n, wr_n;
  logic [7:0] code_byte, rdata, lo_pin, lo_o, lo_oe, hi_o, hi_oe, hi_pu;
  int miscompares = 0, tests_run = 0, ale_cnt, program_store_strobe_cnt, valid_cnt;
  logic [7:0] got_code;

  initial forever #25 clk_i = ~clk_i;

  external_memory_bus_port uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .external_access_select_i(sel), .pc_i(pc), .code_valid_o(code_valid),
    .code_byte_o(code_byte), .xmem_req_i(req), .xmem_wide_i(wide), .xmem_write_i(wr),
    .xmem_addr_i(xaddr), .xmem_wdata_i(wdata), .xmem_busy_o(busy), .xmem_done_o(done),
    .xmem_rdata_o(rdata), .low_latch_wr_i(low_wr), .high_latch_wr_i(high_wr),
    .latch_data_i(latch), .program_store_strobe_n_o(program_store_strobe_n), .address_latch_strobe_o(ale),
    .xdata_read_n_o(rd_n), .xdata_write_n_o(wr_n), .low_address_data_port_i(lo_pin),
    .low_address_data_port_o(lo_o), .low_address_data_port_oe_o(lo_oe),
    .high_address_port_o(hi_o), .high_address_port_oe_o(hi_oe),
    .high_address_port_pullup_o(hi_pu));

  ext_memory_model mem (.clk_i(clk_i), .address_latch_strobe_i(ale),
    .program_store_strobe_n_i(program_store_strobe_n), .xdata_read_n_i(rd_n), .xdata_write_n_i(wr_n),
    .low_port_i(lo_o), .low_port_oe_i(lo_oe), .high_port_i(hi_o), .pin_o(lo_pin));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out

  task automatic set_latch(input logic high, input logic [7:0] v);
    @(negedge clk_i);
    latch = v;
    if (high) high_wr = 1'b1;
    else low_wr = 1'b1;
    @(negedge clk_i);
    high_wr = 1'b0;
    low_wr = 1'b0;
    repeat (2) @(negedge clk_i);
  endtask : set_latch

  // four whole slots: counts are independent of where the window starts
  task automatic window(input logic s, input logic [15:0] a, input logic ext);
    @(negedge clk_i);
    sel = s;
    pc = a;
    ale_cnt = 0;
    program_store_strobe_cnt = 0;
    valid_cnt = 0;
    repeat (14) @(negedge clk_i);
    repeat (24) begin
      @(negedge clk_i);
      ale_cnt += int'(ale);
      program_store_strobe_cnt += int'(!program_store_strobe_n);
      valid_cnt += int'(code_valid);
      if (code_valid) got_code = code_byte;
      if (!program_store_strobe_n) check({hi_oe, hi_o}, {8'hFF, a[15:8]});
    end
    check(16'(ale_cnt), 16'h0008);
    check(16'(program_store_strobe_cnt), ext ? 16'h000C : 16'h0000);
    check(16'(valid_cnt), ext ? 16'h0004 : 16'h0000);
    if (ext) check(16'(got_code), 16'(a[7:0] ^ a[15:8] ^ 8'h3C));
    $display("window pc=%0h sel=%0b done", a, s);
  endtask : window

  // request launched right after a fetch slot starts, so the counts are exact
  task automatic access(input logic w, input logic we, input logic [15:0] a,
                        input logic [7:0] d, input logic [7:0] hi_exp);
    int n;
    n = 0;
    ale_cnt = 0;
    program_store_strobe_cnt = 0;
    while (!code_valid) @(negedge clk_i);
    req = 1'b1;
    wide = w;
    wr = we;
    xaddr = a;
    wdata = d;
    @(negedge clk_i);
    req = 1'b0;
    check(16'(busy), 16'h0001);
    while (!done && n < 30) begin
      n++;
      ale_cnt += int'(ale);
      program_store_strobe_cnt += int'(!program_store_strobe_n);
      if (!wr_n) check({lo_oe, lo_o}, {8'hFF, d});
      if (!rd_n || !wr_n) check({hi_o, hi_pu | hi_oe}, {hi_exp, 8'hFF});
      @(negedge clk_i);
    end
    check(16'(n), 16'h0011);
    check(16'(busy), 16'h0000);
    check(16'(ale_cnt), 16'h0003);
    check(16'(program_store_strobe_cnt), 16'h0003);
    if (!we) check(16'(rdata), 16'(d));
    $display("access addr=%0h write=%0b done", a, we);
  endtask : access

  initial begin
    repeat (3) @(negedge clk_i);
    check({6'h00, program_store_strobe_n, ale, lo_oe}, {6'h00, 2'b10, 8'h00});
    check({hi_o, hi_pu}, 16'hFFFF);
    check({3'h0, rd_n, wr_n, code_valid, busy, done, hi_oe}, 16'h1800);
    repeat (9) @(negedge clk_i);
    rst_n_i = 1'b1;
    window(1'b1, 16'h7FFF, 1'b0);
    check({lo_oe, hi_oe}, 16'h0000);
    check({8'h00, hi_pu}, 16'h00FF);
    set_latch(1'b1, 8'h0F);
    check({hi_oe, hi_pu}, 16'hF00F);
    set_latch(1'b0, 8'h0F);
    check({lo_oe, lo_o & 8'hF0}, 16'hF000);
    set_latch(1'b0, 8'hFF);
    window(1'b1, 16'h8000, 1'b1);
    window(1'b0, 16'h1234, 1'b1);
    access(1'b1, 1'b1, 16'h3456, 8'hA5, 8'h34);
    set_latch(1'b1, 8'h34);
    access(1'b0, 1'b0, 16'h0056, 8'hA5, 8'h34);
    access(1'b0, 1'b1, 16'h0057, 8'h5A, 8'h34);
    access(1'b1, 1'b0, 16'h3457, 8'h5A, 8'h34);
    close_out();
  end

  initial begin
    #(50 * 3000);
    miscompares++;
    close_out();
  end
endmodule : test_external_memory_bus_port
